/* File: core/swc_key_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries key events from the qualifier to the sequencer.
interface swc_key_if;
  logic [4:0] cols;
  logic [7:0] samples;
  logic press;
  logic [4:0] code;
  modport qual (input cols, input samples, output press, output code);
  modport ctrl (output cols, output samples, input press, input code);
endinterface
`default_nettype wire

/* File: core/swc_key_qual.sv */
`timescale 1ns/1ps
`default_nettype none
// Qualifies a key press: held stable for the programmed sample count.
module swc_key_qual
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Key path.
  swc_key_if.qual kif
);

  // Stability counter and last seen pattern.
  logic [7:0] cnt_q;
  logic [4:0] last_q;
  logic done_q;

  ////////////////////////////////////////////////////////////////////
  // Counts cycles the column pattern is nonzero and unchanged.
  // sample time qualification
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 8'h00;
      last_q <= 5'h00;
      done_q <= 1'b0;
      kif.press <= 1'b0;
      kif.code <= 5'h00;
    end
    else
    begin
      last_q <= kif.cols;
      kif.press <= 1'b0;
      if (kif.cols == 5'h00 || kif.cols != last_q)
      begin
        // Released or bouncing: start over.
        cnt_q <= 8'h00;
        done_q <= 1'b0;
      end
      else if (!done_q && cnt_q + 8'h01 >= kif.samples)
      begin
        // One pulse per stable press.
        done_q <= 1'b1;
        kif.press <= 1'b1;
        kif.code <= kif.cols;
      end
      else if (!done_q)
      begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/swc_pkg.sv */
package swc_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h01;
  localparam logic [7:0] TOUCH_CONTROL_ZERO_ADDR = 8'h70;
  localparam logic [7:0] KEY_CONTROL_ONE_ADDR = 8'hc0;
  localparam logic [7:0] KEY_CONTROL_TWO_ADDR = 8'hc1;
  localparam logic [7:0] WAKE_STATUS_ADDR = 8'hd0;
  localparam logic [7:0] WAKE_CLEAR_ADDR = 8'hd1;
  localparam logic [7:0] WAKE_ENABLE_ADDR = 8'hd2;
  localparam logic [7:0] KEY_CODE_ADDR = 8'hd3;
  localparam logic [7:0] PULSE_CTRL_ADDR = 8'hd4;

  // Field positions.
  localparam int SLEEP_BIT = 1;
  localparam int TOUCH_EN_BIT = 7;
  localparam int TOUCH_WAKE_BIT = 3;
  localparam int KEY_EN_BIT = 7;
  localparam int KEY_WAKE_BIT = 7;

  // Status bit positions: 0 touch wake, 1 key wake, 2 key press.
  localparam int ST_TOUCH = 0;
  localparam int ST_KEY = 1;
  localparam int ST_PRESS = 2;
  localparam int ST_W = 3;

  // Reset values.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Key qualification sample counts for key_control_one bits [5:4].
  localparam int KEY_SAMPLE_LSB = 4;
  localparam logic [7:0] KEY_SAMPLE_BASE = 8'h04;

  // Settling time after a wake, in microseconds, and in clock cycles.
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_US = 10000;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;

  // Sleep sequencer states.
  typedef enum logic [1:0] {
    SWC_AWAKE = 2'b00,
    SWC_ASLEEP = 2'b01,
    SWC_SETTLE = 2'b10
  } swc_state_t;

endpackage

/* File: core/swc_top.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module swc_top
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Wake sources.
  input wire logic touch_event,
  input wire logic [4:0] key_cols,
  // Normal pin values from the rest of the device.
  input wire logic [5:0] gpio_norm,
  input wire logic [18:0] mem_addr_norm,
  input wire logic [15:0] pixel_norm,
  input wire logic [6:0] ctl_norm,
  // Clock gate, interrupt and settle flag.
  output logic osc_run,
  output logic wake_irq,
  output logic settled,
  // Pins with sleep values.
  output logic wait_n,
  output logic int_n,
  output logic ram_cs_n,
  output logic ram_wr_n,
  output logic font_cs_n,
  output logic ram_oe_n,
  output logic sync_out,
  output logic pixel_valid,
  output logic [5:0] gpio_out,
  output logic [18:0] mem_addr_bus,
  output logic [15:0] pixel_bus,
  output logic pulse_out_one,
  output logic pulse_out_two
);

  // Width of the wake status, enable and clear fields.
  localparam int ST_W = swc_pkg::ST_W;

  // Registers.
  logic [7:0] power_control_q;
  logic [7:0] touch_control_zero_q;
  logic [7:0] key_control_one_q;
  logic [7:0] key_control_two_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] enable_q;
  logic [4:0] key_code_q;
  logic [1:0] pulse_ctrl_q;

  // Sequencer state and settle counter.
  swc_pkg::swc_state_t state_q;
  logic [31:0] settle_q;
  logic asleep;

  // Wake conditions.
  logic touch_wake;
  logic key_wake;
  logic key_armed;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] clr;

  // Key qualifier.
  swc_key_if kif();

  assign asleep = (state_q == swc_pkg::SWC_ASLEEP);
  assign kif.cols = key_cols;
  assign kif.samples = swc_pkg::KEY_SAMPLE_BASE <<
    key_control_one_q[swc_pkg::KEY_SAMPLE_LSB +: 2];

  swc_key_qual i_swc_key_qual
  (
    .clock(clock),
    .rst(rst),
    .kif(kif)
  );

  ////////////////////////////////////////////////////////////////////
  // Wake decode.
  // touch wake enables
  assign touch_wake = asleep && touch_event &&
    touch_control_zero_q[swc_pkg::TOUCH_EN_BIT] &&
    touch_control_zero_q[swc_pkg::TOUCH_WAKE_BIT];
  assign key_armed = key_control_one_q[swc_pkg::KEY_EN_BIT];
  assign key_wake = asleep && kif.press && key_armed &&
    key_control_two_q[swc_pkg::KEY_WAKE_BIT];
  assign events = {!asleep && kif.press && key_armed, key_wake,
    touch_wake};
  assign clr = (reg_wr && reg_addr == swc_pkg::WAKE_CLEAR_ADDR) ?
    reg_wdata[ST_W-1:0] : '0;

  ////////////////////////////////////////////////////////////////////
  // Power control register.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      power_control_q <= swc_pkg::REG_RESET;
    end
    else if (touch_wake || key_wake)
    begin
      power_control_q[swc_pkg::SLEEP_BIT] <= 1'b0;
    end
    else if (reg_wr && reg_addr == swc_pkg::POWER_CONTROL_ADDR)
    begin
      power_control_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration registers; writes while asleep still land.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      touch_control_zero_q <= swc_pkg::REG_RESET;
      key_control_one_q <= swc_pkg::REG_RESET;
      key_control_two_q <= swc_pkg::REG_RESET;
      enable_q <= '0;
      pulse_ctrl_q <= 2'b00;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        swc_pkg::TOUCH_CONTROL_ZERO_ADDR: touch_control_zero_q <= reg_wdata;
        swc_pkg::KEY_CONTROL_ONE_ADDR: key_control_one_q <= reg_wdata;
        // Low two bits are read-only and always read zero.
        swc_pkg::KEY_CONTROL_TWO_ADDR:
          key_control_two_q <= {reg_wdata[7:2], 2'b00};
        swc_pkg::WAKE_ENABLE_ADDR: enable_q <= reg_wdata[ST_W-1:0];
        swc_pkg::PULSE_CTRL_ADDR: pulse_ctrl_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      status_q <= '0;
    end
    else
    begin
      status_q <= (status_q & ~clr) | events;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Key code capture; the waking press is dropped.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      key_code_q <= 5'h00;
    end
    else if (events[swc_pkg::ST_PRESS])
    begin
      key_code_q <= kif.code;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sleep sequencer with settle delay after wake.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= swc_pkg::SWC_AWAKE;
      settle_q <= 32'h0;
    end
    else
    begin
      unique case (state_q)
        swc_pkg::SWC_AWAKE:
        begin
          if (power_control_q[swc_pkg::SLEEP_BIT])
          begin
            state_q <= swc_pkg::SWC_ASLEEP;
          end
        end
        swc_pkg::SWC_ASLEEP:
        begin
          if (!power_control_q[swc_pkg::SLEEP_BIT])
          begin
            state_q <= swc_pkg::SWC_SETTLE;
            settle_q <= 32'h0;
          end
        end
        swc_pkg::SWC_SETTLE:
        begin
          // A new sleep request is honoured at once, settle or not.
          if (power_control_q[swc_pkg::SLEEP_BIT])
          begin
            state_q <= swc_pkg::SWC_ASLEEP;
          end
          else if (settle_q == 32'(swc_pkg::SETTLE_CYCLES - 1))
          begin
            state_q <= swc_pkg::SWC_AWAKE;
          end
          else
          begin
            settle_q <= settle_q + 32'h1;
          end
        end
        default: state_q <= swc_pkg::SWC_AWAKE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered read port.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        swc_pkg::POWER_CONTROL_ADDR: reg_rdata <= power_control_q;
        swc_pkg::TOUCH_CONTROL_ZERO_ADDR: reg_rdata <= touch_control_zero_q;
        swc_pkg::KEY_CONTROL_ONE_ADDR: reg_rdata <= key_control_one_q;
        swc_pkg::KEY_CONTROL_TWO_ADDR: reg_rdata <= key_control_two_q;
        swc_pkg::WAKE_STATUS_ADDR: reg_rdata <= 8'(status_q);
        swc_pkg::WAKE_ENABLE_ADDR: reg_rdata <= 8'(enable_q);
        swc_pkg::KEY_CODE_ADDR: reg_rdata <= {3'b000, key_code_q};
        swc_pkg::PULSE_CTRL_ADDR: reg_rdata <= {6'h00, pulse_ctrl_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt, clock gate and settle flag.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wake_irq <= 1'b0;
      osc_run <= 1'b1;
      settled <= 1'b1;
    end
    else
    begin
      wake_irq <= |(status_q & enable_q);
      osc_run <= !asleep;
      settled <= (state_q == swc_pkg::SWC_AWAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin levels: fixed asleep, normal otherwise except sync_out, held high, and int_n, also low on wake_irq; pulse outputs follow pulse_ctrl_q in both.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {wait_n, int_n, ram_cs_n, ram_wr_n, font_cs_n} <= 5'h1f;
      ram_oe_n <= 1'b1;
      sync_out <= 1'b1;
      pixel_valid <= 1'b0;
      gpio_out <= 6'h00;
      mem_addr_bus <= 19'h00000;
      pixel_bus <= 16'h0000;
      pulse_out_one <= 1'b0;
      pulse_out_two <= 1'b0;
    end
    else
    begin
      pulse_out_one <= pulse_ctrl_q[0];
      pulse_out_two <= pulse_ctrl_q[1];
      if (asleep)
      begin
        {wait_n, int_n, ram_cs_n, ram_wr_n, font_cs_n} <= 5'h1f;
        ram_oe_n <= 1'b0;
        sync_out <= 1'b1;
        pixel_valid <= 1'b1;
        gpio_out <= 6'h00;
        mem_addr_bus <= 19'h00000;
        pixel_bus <= 16'h0000;
      end
      else
      begin
        wait_n <= ctl_norm[0];
        int_n <= ctl_norm[1] & !wake_irq;
        ram_cs_n <= ctl_norm[2];
        ram_wr_n <= ctl_norm[3];
        font_cs_n <= ctl_norm[4];
        ram_oe_n <= ctl_norm[5];
        sync_out <= 1'b1;
        pixel_valid <= ctl_norm[6];
        gpio_out <= gpio_norm;
        mem_addr_bus <= mem_addr_norm;
        pixel_bus <= pixel_norm;
      end
    end
  end

endmodule
`default_nettype wire

/* File: verification/swc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model: one strobe at a time on the register port.
module swc_host
(
  // Clock.
  input wire logic clock,
  // Register port.
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus from time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // One read cycle; the data stand in the cycle after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // arm then sleep
  // Wake sources are armed before the sleep bit is set.
  task automatic nap(input logic [7:0] tp, input logic [7:0] k1);
    wr(8'h70, tp);
    wr(8'hc0, k1);
    wr(8'hc1, k1);
    wr(8'h01, 8'h02);
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* File: verification/swc_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the sleep controller at its top ports.
module swc_top_sva
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port and wake sources.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic touch_event,
  input wire logic [4:0] key_cols,
  // Observed outputs.
  input wire logic osc_run,
  input wire logic settled,
  input wire logic wait_n,
  input wire logic int_n,
  input wire logic ram_cs_n,
  input wire logic ram_wr_n,
  input wire logic font_cs_n,
  input wire logic ram_oe_n,
  input wire logic sync_out,
  input wire logic pixel_valid,
  input wire logic [5:0] gpio_out,
  input wire logic [18:0] mem_addr_bus,
  input wire logic [15:0] pixel_bus,
  input wire logic pulse_out_one,
  input wire logic pulse_out_two
);
  // Shadow copies of the registers that arm the wake sources, and of the pulse control.
  logic [7:0] tp_q, k1_q, k2_q, pc_q;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows follow every host write.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tp_q <= 8'h00;
      k1_q <= 8'h00;
      k2_q <= 8'h00;
      pc_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h70)
        tp_q <= reg_wdata;
      if (reg_addr == 8'hc0)
        k1_q <= reg_wdata;
      if (reg_addr == 8'hc1)
        k2_q <= reg_wdata;
      if (reg_addr == 8'hd4)
        pc_q <= reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (rst);
  // Host asks for sleep.
  sequence sleep_wr;
    reg_wr && reg_addr == 8'h01 && reg_wdata[1];
  endsequence
  // A fresh press of an armed key while asleep.
  sequence key_start;
    key_cols == 5'h00 ##1 (!osc_run && k1_q[7] && k2_q[7] &&
      k1_q[5:4] == 2'b00 && key_cols != 5'h00);
  endsequence
  // The same key held for the four samples that qualify it.
  sequence key_held;
    key_start ##1 (!osc_run && k1_q[7] && k2_q[7] &&
      key_cols != 5'h00 && $stable(key_cols))[*4];
  endsequence
  enter_sleep_a: assert property (sleep_wr |-> ##3 !osc_run)
    else $error("sleep request did not stop the oscillator");
  sleep_high_a: assert property (!osc_run |-> wait_n && int_n &&
    ram_cs_n && ram_wr_n && font_cs_n && sync_out && pixel_valid)
    else $error("a pin is not high while asleep");
  sleep_low_a: assert property (!osc_run |-> !ram_oe_n &&
    gpio_out == 6'h00 && mem_addr_bus == 19'h00000 && pixel_bus == 16'h0000)
    else $error("a pin is not low while asleep");
  wake_write_a: assert property (!osc_run && reg_wr &&
    reg_addr == 8'h01 && !reg_wdata[1] |-> ##[1:4] osc_run)
    else $error("clearing the sleep bit did not wake");
  touch_wake_a: assert property (!osc_run && touch_event &&
    tp_q[7] && tp_q[3] |-> ##[1:4] osc_run)
    else $error("armed touch did not wake");
  key_wake_a: assert property (key_held |-> ##[1:8] osc_run)
    else $error("armed keystroke did not wake");
  pulse_hold_a: assert property (!osc_run && $stable(pc_q) |->
    pulse_out_one == pc_q[0] && pulse_out_two == pc_q[1])
    else $error("pulse outputs lost their level asleep");
  settle_wait_a: assert property ($rose(osc_run) |-> !settled[*8])
    else $error("settled rose too early after wake");
endmodule
bind swc_top swc_top_sva i_swc_top_sva (.clock, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .touch_event, .key_cols, .osc_run, .settled,
  .wait_n, .int_n, .ram_cs_n, .ram_wr_n, .font_cs_n, .ram_oe_n, .sync_out,
  .pixel_valid, .gpio_out, .mem_addr_bus, .pixel_bus, .pulse_out_one,
  .pulse_out_two);
`default_nettype wire

/* File: verification/test_sleep_wake_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Exercises sleep entry, the three wake paths and the sleep pin levels.
module test_sleep_wake_control;
  // Clock, reset and wake stimulus.
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic touch_event = 1'b0;
  logic [4:0] key_cols = 5'h00;
  // Awake pin values, chosen opposite to the sleep levels except for ram_oe_n.
  logic [5:0] gpio_norm = 6'h3f;
  logic [18:0] mem_addr_norm = 19'h7ffff;
  logic [15:0] pixel_norm = 16'hffff;
  logic [6:0] ctl_norm = 7'h00;
  // Register port.
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd;
  // Outputs.
  logic osc_run, wake_irq, settled, wait_n, int_n, ram_cs_n, ram_wr_n;
  logic font_cs_n, ram_oe_n, sync_out, pixel_valid;
  logic pulse_out_one, pulse_out_two;
  logic [5:0] gpio_out;
  logic [18:0] mem_addr_bus;
  logic [15:0] pixel_bus;
  int err_count = 0;
  int check_count = 0;
  always #12.5 clock = ~clock;
  swc_host i_swc_host (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);
  swc_top i_swc_top (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .touch_event, .key_cols, .gpio_norm, .mem_addr_norm,
    .pixel_norm, .ctl_norm, .osc_run, .wake_irq, .settled, .wait_n, .int_n,
    .ram_cs_n, .ram_wr_n, .font_cs_n, .ram_oe_n, .sync_out, .pixel_valid,
    .gpio_out, .mem_addr_bus, .pixel_bus, .pulse_out_one, .pulse_out_two);
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string n, input logic [18:0] e,
    input logic [18:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Lets a few edges pass, then looks once outputs have settled.
  task automatic pause(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Sleep by register with an unarmed touch, then wake by register.
  task automatic t_sleep();
    i_swc_host.rd(8'h33, d);
    chk("unmapped read", 8'h00, d);
    chk("awake settled", 1'b1, settled);
    chk("awake osc_run", 1'b1, osc_run);
    chk("awake gpio_out", 6'h3f, gpio_out);
    chk("awake mem_addr_bus", 19'h7ffff, mem_addr_bus);
    chk("awake pixel_bus", 16'hffff, pixel_bus);
    i_swc_host.nap(8'h08, 8'h00);
    touch_event <= 1'b1;
    pause(4);
    chk("osc_run", 1'b0, osc_run);
    chk("high pins", 7'h7f, {wait_n, int_n, ram_cs_n, ram_wr_n, font_cs_n,
      sync_out, pixel_valid});
    chk("low pins", 17'h0, {ram_oe_n, pixel_bus});
    chk("gpio_out", 6'h00, gpio_out);
    chk("mem_addr_bus", 19'h0, mem_addr_bus);
    @(posedge clock);
    touch_event <= 1'b0;
    i_swc_host.rd(8'h01, d);
    chk("power_control", 8'h02, d);
    i_swc_host.wr(8'h01, 8'h00);
    pause(5);
    chk("osc_run", 1'b1, osc_run);
    chk("settled", 1'b0, settled);
    $display("t_sleep done");
  endtask
  // Touch wake, pulse levels asleep, and the wake interrupt.
  task automatic t_touch();
    i_swc_host.wr(8'hd4, 8'h03);
    i_swc_host.nap(8'h88, 8'h00);
    chk("pulse outs", 2'b11, {pulse_out_two, pulse_out_one});
    @(posedge clock);
    touch_event <= 1'b1;
    @(posedge clock);
    touch_event <= 1'b0;
    pause(5);
    chk("osc_run", 1'b1, osc_run);
    i_swc_host.rd(8'h01, d);
    chk("power_control", 8'h00, d);
    chk("masked irq", 1'b0, wake_irq);
    i_swc_host.wr(8'hd2, 8'h01);
    pause(2);
    chk("enabled irq", 1'b1, wake_irq);
    i_swc_host.wr(8'hd1, 8'h01);
    pause(2);
    chk("cleared irq", 1'b0, wake_irq);
    $display("t_touch done");
  endtask
  // A short glitch must not wake; a qualified keystroke must.
  task automatic t_key();
    i_swc_host.nap(8'h00, 8'h80);
    @(posedge clock);
    key_cols <= 5'h01;
    repeat (2) @(posedge clock);
    key_cols <= 5'h00;
    pause(6);
    chk("osc_run", 1'b0, osc_run);
    @(posedge clock);
    key_cols <= 5'h01;
    repeat (12) @(posedge clock);
    key_cols <= 5'h00;
    pause(4);
    chk("osc_run", 1'b1, osc_run);
    i_swc_host.rd(8'hd3, d);
    chk("key code", 8'h00, d);
    i_swc_host.rd(8'hd0, d);
    chk("wake status", 8'h02, d);
    $display("t_key done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_sleep();
    t_touch();
    t_key();
    wrap_up();
  end
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial
  begin
    repeat (3000) @(posedge clock);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
